// file: spmbs_consts.svh
/*
  Constants of the serial port block: register indexes, field positions,
  reset values and timing counts.
  Assumes byte address = 4 * register index on a 32-bit APB.
*/
// Functional notes
// - baud timer select set: dedicated timer sets rate; doubler and timer2 selects ignored
// - baud timer select clear: rate from legacy timers and doubler setting
// - fraction divide value sits in bits 5..0 and resets to zero
// - bit 6 of fraction register has no function; writes have no effect
// - both mode select bits zero selects shift-register mode
// - shift mode: data in and out on receive pin, transmit pin gives clock
// - shift mode: bit rate is core clock over 12, eight bits per transfer
// - shift mode: buffer write starts transmission, eight bits LSB first on receive pin
// - shift mode: reception starts when receive enable is one and receive done zero
// - upper mode bit zero, lower one selects 8-bit asynchronous mode
// - async frame: zero start, eight data bits LSB first, one stop
// - async rate from timer overflow; transmit and receive may use different timers
// - async buffer write starts transmit; done flag set when stop bit leaves; here set as the stop bit starts
// - async receive starts on falling edge, continues only with valid start bit
// - enhanced option off: accept only if receive done flag zero at final pulse
// - frame check enabled: accept only if received stop bit is one
// - failed acceptance discards frame and leaves receive done flag unchanged
// - accepted frame: load buffer, stop bit into ninth bit flag, set done
// - overrun flag set when character arrives with receive done set; write zero clears
// - framing error flag tracks missing stop bit, updated on every frame
`ifndef SPMBS_CONSTS_SVH
`define SPMBS_CONSTS_SVH

`define SPMBS_IDX_POWER_CONTROL_REG 8'h87
`define SPMBS_IDX_SERIAL_CONTROL_REG 8'h98
`define SPMBS_IDX_SERIAL_BUFFER 8'h99
`define SPMBS_IDX_BFC 8'h9D
`define SPMBS_IDX_IBR 8'h9E
`define SPMBS_IDX_CFG 8'hAF
`define SPMBS_IDX_TIMER2_CONTROL_REG 8'hC8

`define SPMBS_BFC_SEL 7
`define SPMBS_IBR_OVR 7
`define SPMBS_POWER_CONTROL_REG_DBL 7
`define SPMBS_T2_RCLK 5
`define SPMBS_T2_TIMER2_TX_CLOCK_SELECT 4
`define SPMBS_CFG_ENH 0

`define SPMBS_RST_SERIAL_CONTROL_REG 8'h00
`define SPMBS_RST_BFC 7'h00
`define SPMBS_RST_IBR 7'h00
`define SPMBS_RST_BYTE 8'h00

`define SPMBS_M0_DIV 4'hB
`define SPMBS_M0_HIGH 4'h5
`define SPMBS_OVS_LAST 4'hF
`define SPMBS_OVS_MID 4'h7
`define SPMBS_BITS 4'h8
`define SPMBS_TX_STOP 4'h9
`define SPMBS_TX_END 4'hA

`endif

// file: spmbs_pkg.sv
/*
  Types of the serial port block.
  Assumes spmbs_consts.svh for numeric constants.
*/
package spmbs_pkg;

  typedef enum logic [1:0] {TX_IDLE, TX_M0, TX_M1} spmbs_tx_state_type;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_M0}
    spmbs_rx_state_type;

  // serial control register layout, msb first
  typedef struct packed {
    logic mode_up;
    logic mode_lo;
    logic fchk;
    logic ren;
    logic tb8;
    logic rb8;
    logic ti;
    logic ri;
  } spmbs_serial_control_reg_type;

  typedef struct packed {
    logic sel;
    logic [5:0] frac;
  } spmbs_bfc_type;

  typedef struct packed {
    logic ovr;
    logic fe;
    logic [1:0] extended_divide_ratio;
    logic [2:0] div;
  } spmbs_ibr_type;

endpackage : spmbs_pkg

// file: spmbs_top.sv
/*
  Serial port: shift-register mode and 8-bit asynchronous mode, with the
  dedicated fractional baud timer and legacy timer baud selection.
  Assumes timer overflow pulses on ref_clk and an APB master on ref_clk;
  the serial pins are asynchronous.
*/
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`include "spmbs_consts.svh"

module spmbs_top #(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // legacy timer overflow pulses
  input wire logic t1_ovf,
  input wire logic t2_ovf,
  // serial pins
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe,
  output logic txd
);

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] idx);
    hit = (a == ADDR_W'({idx, 2'b00}));
  endfunction : hit

  // picks the 16x oversample tick for one direction
  function automatic logic pick_tick(input logic use_bt, input logic bt,
                                     input logic use_t2, input logic t2,
                                     input logic t1);
    if (use_bt) begin
      pick_tick = bt;
    end else if (use_t2) begin
      pick_tick = t2;
    end else begin
      pick_tick = t1;
    end
  endfunction : pick_tick

  spmbs_pkg::spmbs_serial_control_reg_type serial_control_reg_q;
  spmbs_pkg::spmbs_bfc_type bfc_q;
  spmbs_pkg::spmbs_ibr_type ibr_q;
  spmbs_pkg::spmbs_tx_state_type tx_state_q;
  spmbs_pkg::spmbs_rx_state_type rx_state_q;
  logic [7:0] rxbuf_q;
  logic enh_q, dbl_q, timer2_tx_clock_select_q, rclk_q;
  logic [31:0] prdata_q, rd_d;
  logic mapped, access, wr_en;
  logic w_serial_control_reg, w_serial_buffer, w_bfc, w_ibr, w_cfg, w_power_control_reg, w_t2;
  logic rxd_s1_q, rxd_s2_q, rxd_prev_q;
  logic [9:0] bt_cnt_q, bt_limit;
  logic [5:0] bt_acc_q;
  logic [6:0] bt_sum;
  logic bt_extra_q, bt_tick;
  logic t1_half_q, t1_tick16, tx_tick16, rx_tick16;
  logic mode0, mode1;
  logic [3:0] m0_phase_q;
  logic m0_clk_q, m0_act, m0_end, m0_start;
  logic [9:0] tx_shift_q;
  logic [3:0] tx_div_q, tx_bits_q;
  logic tx_line_q, tx_bit_tick, ti_set;
  logic [7:0] rx_shift_q;
  logic [3:0] rx_div_q, rx_bits_q;
  logic rx_final, rx_accept, m0_rx_done, ri_set;

  // apb slave, zero wait states
  assign access = psel & penable;
  assign pready = 1'b1;
  assign wr_en = access & pwrite;
  assign w_serial_control_reg = wr_en & hit(paddr, `SPMBS_IDX_SERIAL_CONTROL_REG);
  assign w_serial_buffer = wr_en & hit(paddr, `SPMBS_IDX_SERIAL_BUFFER);
  assign w_bfc = wr_en & hit(paddr, `SPMBS_IDX_BFC);
  assign w_ibr = wr_en & hit(paddr, `SPMBS_IDX_IBR);
  assign w_cfg = wr_en & hit(paddr, `SPMBS_IDX_CFG);
  assign w_power_control_reg = wr_en & hit(paddr, `SPMBS_IDX_POWER_CONTROL_REG);
  assign w_t2 = wr_en & hit(paddr, `SPMBS_IDX_TIMER2_CONTROL_REG);
  assign pslverr = access & ~mapped;
  assign prdata = prdata_q;

  always_comb begin
    rd_d = 32'h0000_0000;
    mapped = 1'b1;
    if (hit(paddr, `SPMBS_IDX_SERIAL_CONTROL_REG)) begin
      rd_d[7:0] = serial_control_reg_q;
    end else if (hit(paddr, `SPMBS_IDX_SERIAL_BUFFER)) begin
      rd_d[7:0] = rxbuf_q;
    end else if (hit(paddr, `SPMBS_IDX_BFC)) begin
      rd_d[7:0] = {bfc_q.sel, 1'b0, bfc_q.frac};
    end else if (hit(paddr, `SPMBS_IDX_IBR)) begin
      rd_d[7:0] = {ibr_q.ovr, ibr_q.fe, 1'b0, ibr_q.extended_divide_ratio, ibr_q.div};
    end else if (hit(paddr, `SPMBS_IDX_CFG)) begin
      rd_d[`SPMBS_CFG_ENH] = enh_q;
    end else if (hit(paddr, `SPMBS_IDX_POWER_CONTROL_REG)) begin
      rd_d[`SPMBS_POWER_CONTROL_REG_DBL] = dbl_q;
    end else if (hit(paddr, `SPMBS_IDX_TIMER2_CONTROL_REG)) begin
      rd_d[`SPMBS_T2_RCLK] = rclk_q;
      rd_d[`SPMBS_T2_TIMER2_TX_CLOCK_SELECT] = timer2_tx_clock_select_q;
    end else begin
      mapped = 1'b0;
    end
  end

  // read data is captured in the setup phase
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_q <= rd_d;
    end
  end

  // configuration registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      bfc_q <= `SPMBS_RST_BFC;
      enh_q <= 1'b0;
      dbl_q <= 1'b0;
      timer2_tx_clock_select_q <= 1'b0;
      rclk_q <= 1'b0;
    end else begin
      if (w_bfc) begin
        bfc_q <= {pwdata[`SPMBS_BFC_SEL], pwdata[5:0]};
      end
      if (w_cfg) begin
        enh_q <= pwdata[`SPMBS_CFG_ENH];
      end
      if (w_power_control_reg) begin
        dbl_q <= pwdata[`SPMBS_POWER_CONTROL_REG_DBL];
      end
      if (w_t2) begin
        timer2_tx_clock_select_q <= pwdata[`SPMBS_T2_TIMER2_TX_CLOCK_SELECT];
        rclk_q <= pwdata[`SPMBS_T2_RCLK];
      end
    end
  end

  // integer baud register with overrun and framing flags
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ibr_q <= `SPMBS_RST_IBR;
    end else begin
      if (w_ibr) begin
        ibr_q.extended_divide_ratio <= pwdata[4:3];
        ibr_q.div <= pwdata[2:0];
        if (!pwdata[`SPMBS_IBR_OVR]) begin
          ibr_q.ovr <= 1'b0;
        end
      end
      if (rx_final && serial_control_reg_q.ri) begin
        ibr_q.ovr <= 1'b1;
      end
      if (rx_final) begin
        ibr_q.fe <= ~rxd_s2_q;
      end
    end
  end

  // serial control: hardware sets win over software writes
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      serial_control_reg_q <= `SPMBS_RST_SERIAL_CONTROL_REG;
    end else begin
      if (w_serial_control_reg) begin
        serial_control_reg_q <= spmbs_pkg::spmbs_serial_control_reg_type'(pwdata[7:0]);
      end
      if (ri_set) begin
        serial_control_reg_q.ri <= 1'b1;
      end
      if (ti_set) begin
        serial_control_reg_q.ti <= 1'b1;
      end
      if (rx_accept) begin
        serial_control_reg_q.rb8 <= rxd_s2_q;
      end
    end
  end

  // receive pin synchroniser and edge history
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rxd_s1_q <= 1'b1;
      rxd_s2_q <= 1'b1;
      rxd_prev_q <= 1'b1;
    end else begin
      rxd_s1_q <= rxd_in;
      rxd_s2_q <= rxd_s1_q;
      rxd_prev_q <= rxd_s2_q;
    end
  end

  // dedicated baud timer: (extended_divide_ratio+1)<<div cycles per tick, plus one
  // stretch cycle whenever the fraction accumulator wraps
  assign bt_limit = ((10'(ibr_q.extended_divide_ratio) + 10'h001) << ibr_q.div) - 10'h001;
  assign bt_sum = {1'b0, bt_acc_q} + {1'b0, bfc_q.frac};
  assign bt_tick = bfc_q.sel & ~bt_extra_q & (bt_cnt_q == bt_limit);

  always_ff @(posedge ref_clk) begin
    if (!rst_n || !bfc_q.sel) begin
      bt_cnt_q <= 10'h000;
      bt_acc_q <= 6'h00;
      bt_extra_q <= 1'b0;
    end else if (bt_extra_q) begin
      bt_extra_q <= 1'b0;
    end else if (bt_cnt_q == bt_limit) begin
      bt_cnt_q <= 10'h000;
      bt_acc_q <= bt_sum[5:0];
      bt_extra_q <= bt_sum[6];
    end else begin
      bt_cnt_q <= bt_cnt_q + 10'h001;
    end
  end

  // timer 1 gives 32 overflows per bit, or 16 with the doubler
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      t1_half_q <= 1'b0;
    end else if (t1_ovf) begin
      t1_half_q <= ~t1_half_q;
    end
  end

  assign t1_tick16 = t1_ovf & (dbl_q | t1_half_q);
  assign tx_tick16 = pick_tick(bfc_q.sel, bt_tick, timer2_tx_clock_select_q, t2_ovf,
                               t1_tick16);
  assign rx_tick16 = pick_tick(bfc_q.sel, bt_tick, rclk_q, t2_ovf,
                               t1_tick16);

  assign mode0 = ~serial_control_reg_q.mode_up & ~serial_control_reg_q.mode_lo;
  assign mode1 = ~serial_control_reg_q.mode_up & serial_control_reg_q.mode_lo;

  // shift-mode clock: 12 core cycles per bit, low half then high half
  assign m0_act = (tx_state_q == spmbs_pkg::TX_M0) ||
                  (rx_state_q == spmbs_pkg::RX_M0);
  assign m0_end = m0_act & (m0_phase_q == `SPMBS_M0_DIV);
  // a transfer about to start pulls the clock low for its first bit
  assign m0_start = mode0 && (tx_state_q == spmbs_pkg::TX_IDLE) &&
                    (rx_state_q == spmbs_pkg::RX_IDLE) &&
                    (w_serial_buffer || (serial_control_reg_q.ren && !serial_control_reg_q.ri));

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      m0_phase_q <= 4'h0;
      m0_clk_q <= 1'b1;
    end else if (!m0_act) begin
      m0_phase_q <= 4'h0;
      m0_clk_q <= ~m0_start;
    end else begin
      m0_phase_q <= m0_end ? 4'h0 : m0_phase_q + 4'h1;
      // after the eighth bit the clock returns high: no extra pulse
      m0_clk_q <= m0_end ? (ti_set | m0_rx_done)
                         : (m0_phase_q >= `SPMBS_M0_HIGH);
    end
  end

  // transmit pin: shift clock in mode 0, serial line in mode 1
  assign txd = m0_clk_q & tx_line_q;
  assign rxd_out = tx_shift_q[0];
  assign rxd_oe = (tx_state_q == spmbs_pkg::TX_M0);

  // transmitter
  assign tx_bit_tick = tx_tick16 & (tx_div_q == `SPMBS_OVS_LAST);
  assign ti_set = ((tx_state_q == spmbs_pkg::TX_M1) && tx_bit_tick &&
                   (tx_bits_q == `SPMBS_TX_STOP)) ||
                  ((tx_state_q == spmbs_pkg::TX_M0) && m0_end &&
                   (tx_bits_q == `SPMBS_BITS - 4'h1));

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tx_div_q <= 4'h0;
    end else if (tx_tick16) begin
      tx_div_q <= tx_div_q + 4'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tx_state_q <= spmbs_pkg::TX_IDLE;
      tx_shift_q <= 10'h3FF;
      tx_bits_q <= 4'h0;
      tx_line_q <= 1'b1;
    end else begin
      unique case (tx_state_q)
        spmbs_pkg::TX_IDLE: begin
          tx_bits_q <= 4'h0;
          tx_line_q <= 1'b1;
          if (w_serial_buffer && mode0 && rx_state_q == spmbs_pkg::RX_IDLE) begin
            tx_shift_q <= {2'b11, pwdata[7:0]};
            tx_state_q <= spmbs_pkg::TX_M0;
          end else if (w_serial_buffer && mode1) begin
            tx_shift_q <= {1'b1, pwdata[7:0], 1'b0};
            tx_state_q <= spmbs_pkg::TX_M1;
          end
        end
        spmbs_pkg::TX_M0: begin
          if (m0_end) begin
            tx_shift_q <= {1'b1, tx_shift_q[9:1]};
            tx_bits_q <= tx_bits_q + 4'h1;
            if (tx_bits_q == `SPMBS_BITS - 4'h1) begin
              tx_state_q <= spmbs_pkg::TX_IDLE;
            end
          end
        end
        spmbs_pkg::TX_M1: begin
          if (tx_bit_tick) begin
            if (tx_bits_q == `SPMBS_TX_END) begin
              tx_state_q <= spmbs_pkg::TX_IDLE;
            end else begin
              tx_line_q <= tx_shift_q[0];
              tx_shift_q <= {1'b1, tx_shift_q[9:1]};
              tx_bits_q <= tx_bits_q + 4'h1;
            end
          end
        end
        default: begin
          tx_state_q <= spmbs_pkg::TX_IDLE;
        end
      endcase
    end
  end

  // receiver
  assign rx_final = (rx_state_q == spmbs_pkg::RX_DATA) && rx_tick16 &&
                    (rx_div_q == `SPMBS_OVS_LAST) &&
                    (rx_bits_q == `SPMBS_BITS);
  assign rx_accept = rx_final && (enh_q || !serial_control_reg_q.ri) &&
                     (!serial_control_reg_q.fchk || rxd_s2_q);
  assign m0_rx_done = (rx_state_q == spmbs_pkg::RX_M0) && m0_end &&
                      (rx_bits_q == `SPMBS_BITS - 4'h1);
  assign ri_set = rx_accept | m0_rx_done;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rx_state_q <= spmbs_pkg::RX_IDLE;
      rx_shift_q <= `SPMBS_RST_BYTE;
      rx_div_q <= 4'h0;
      rx_bits_q <= 4'h0;
      rxbuf_q <= `SPMBS_RST_BYTE;
    end else begin
      unique case (rx_state_q)
        spmbs_pkg::RX_IDLE: begin
          rx_div_q <= 4'h0;
          rx_bits_q <= 4'h0;
          if (mode0 && serial_control_reg_q.ren && !serial_control_reg_q.ri &&
              tx_state_q == spmbs_pkg::TX_IDLE && !w_serial_buffer) begin
            rx_state_q <= spmbs_pkg::RX_M0;
          end else if (mode1 && serial_control_reg_q.ren && rxd_prev_q && !rxd_s2_q) begin
            rx_state_q <= spmbs_pkg::RX_START;
          end
        end
        spmbs_pkg::RX_M0: begin
          if (m0_end) begin
            rx_shift_q <= {rxd_s2_q, rx_shift_q[7:1]};
            rx_bits_q <= rx_bits_q + 4'h1;
            if (rx_bits_q == `SPMBS_BITS - 4'h1) begin
              rxbuf_q <= {rxd_s2_q, rx_shift_q[7:1]};
              rx_state_q <= spmbs_pkg::RX_IDLE;
            end
          end
        end
        spmbs_pkg::RX_START: begin
          if (!serial_control_reg_q.ren) begin
            rx_state_q <= spmbs_pkg::RX_IDLE;
          end else if (rx_tick16) begin
            rx_div_q <= rx_div_q + 4'h1;
            if (rx_div_q == `SPMBS_OVS_MID) begin
              rx_div_q <= 4'h0;
              // false start if the line is high again mid bit
              rx_state_q <= rxd_s2_q ? spmbs_pkg::RX_IDLE
                                     : spmbs_pkg::RX_DATA;
            end
          end
        end
        spmbs_pkg::RX_DATA: begin
          if (!serial_control_reg_q.ren) begin
            rx_state_q <= spmbs_pkg::RX_IDLE;
          end else if (rx_tick16) begin
            rx_div_q <= rx_div_q + 4'h1;
            if (rx_div_q == `SPMBS_OVS_LAST) begin
              if (rx_bits_q == `SPMBS_BITS) begin
                if (rx_accept) begin
                  rxbuf_q <= rx_shift_q;
                end
                rx_state_q <= spmbs_pkg::RX_IDLE;
              end else begin
                rx_shift_q <= {rxd_s2_q, rx_shift_q[7:1]};
                rx_bits_q <= rx_bits_q + 4'h1;
              end
            end
          end
        end
        default: begin
          rx_state_q <= spmbs_pkg::RX_IDLE;
        end
      endcase
    end
  end

endmodule : spmbs_top

// file: spmbs_far_model.sv
/*
  Far-end partner: mode-0 shift peripheral and async serial line.
  Assumes BIT ref_clk cycles per async bit; the line idles at mark.
*/
`timescale 1ns/1ps
module spmbs_far_model #(
  parameter int BIT = 16
) (
  // clock
  input wire logic ref_clk,
  // device pins
  input wire logic txd,
  input wire logic rxd_out,
  output logic rxd_in
);
  initial rxd_in = 1'b1;

  // shift peripheral takes data on the rising shift clock
  task automatic get_m0(output logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      @(posedge txd);
      b[i] = rxd_out;
    end
  endtask : get_m0

  task automatic put_m0(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      @(negedge txd);
      rxd_in <= b[i];
    end
    repeat (12) @(posedge ref_clk);
    rxd_in <= 1'b1;
  endtask : put_m0

  // samples mid bit, from the start edge on
  task automatic get_uart(output logic [7:0] b, output logic s);
    @(negedge txd);
    repeat (BIT / 2) @(posedge ref_clk);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT) @(posedge ref_clk);
      if (i < 8) begin
        b[i] = txd;
      end else begin
        s = txd;
      end
    end
  endtask : get_uart

  // g: a short low glitch ahead of the frame
  task automatic put_uart(input logic [7:0] b, input logic s, input bit g);
    logic [9:0] f;
    f = {s, b, 1'b0};
    if (g) begin
      @(posedge ref_clk);
      rxd_in <= 1'b0;
      repeat (3) @(posedge ref_clk);
      rxd_in <= 1'b1;
      repeat (40) @(posedge ref_clk);
    end
    for (int i = 0; i < 10; i++) begin
      @(posedge ref_clk);
      rxd_in <= f[i];
      repeat (BIT - 1) @(posedge ref_clk);
    end
    @(posedge ref_clk);
    rxd_in <= 1'b1;
    repeat (BIT) @(posedge ref_clk);
  endtask : put_uart
endmodule : spmbs_far_model

// file: spmbs_checker.sv
/*
  Assertions on the serial port top ports.
  Assumes zero-wait apb and 12-cycle mode-0 bits.
*/
`timescale 1ns/1ps
module spmbs_checker #(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins
  input wire logic rxd_oe,
  input wire logic rxd_out,
  input wire logic txd
);
  logic [7:0] oe_cnt_q;
  logic [7:0] oe_cnt_d;
  logic hit;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  assign hit = paddr[1:0] == 2'h0 && paddr[ADDR_W-1:10] == '0 &&
    paddr[9:2] inside {8'h87, 8'h98, 8'h99, 8'h9D, 8'h9E, 8'hAF, 8'hC8};
  assign oe_cnt_d = rxd_oe ? oe_cnt_q + 8'h01 : 8'h00;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      oe_cnt_q <= 8'h00;
    end else begin
      oe_cnt_q <= oe_cnt_d;
    end
  end
  sequence acc_s;
    psel && penable;
  endsequence
  sequence m0_bit_s;
    $fell(txd) && rxd_oe;
  endsequence
  pready_hi_a: assert property (acc_s |-> pready)
    else $error("pready low in access");
  err_map_a: assert property (acc_s |-> pslverr == !hit)
    else $error("pslverr wrong for address");
  rd_zero_a: assert property (acc_s ##0 (!pwrite && !hit) |-> prdata == 0)
    else $error("unmapped read not zero");
  err_idle_a: assert property (!(psel && penable) |-> !pslverr)
    else $error("pslverr outside access");
  rd_upper_a: assert property (acc_s |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  oe_span_a: assert property ($fell(rxd_oe) |-> oe_cnt_q == 8'h60)
    else $error("shift transfer not 96 cycles");
  clk_shape_a: assert property (m0_bit_s |-> ##1 (!txd)[*5] ##1 txd[*6])
    else $error("shift clock not 6 low 6 high");
  data_hold_a: assert property (m0_bit_s |-> ##1 $stable(rxd_out)[*8])
    else $error("shift data moved mid bit");
  reset_idle_a: assert property ($rose(rst_n) |-> txd && !rxd_oe)
    else $error("pins not idle after reset");
endmodule : spmbs_checker

bind spmbs_top spmbs_checker #(.ADDR_W(ADDR_W)) u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .rxd_oe(rxd_oe), .rxd_out(rxd_out), .txd(txd));

// file: tb_top.sv
/*
  Self-checking bench for the serial port top.
  Assumes the far model on the pins and 16 cycles per async bit.
*/
`timescale 1ns/1ps
`include "spmbs_consts.svh"
module tb_top;
  logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic t1_ovf, t2_ovf, rxd_in, rxd_out, rxd_oe, txd, s, e;
  logic [7:0] r, b, g;
  int fails, checks;
  localparam logic [7:0] RIDX [7] = '{8'h87, 8'h98, 8'h99, 8'h9D, 8'h9E,
    8'hAF, 8'hC8};

  spmbs_top #(.ADDR_W(12)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .t1_ovf(t1_ovf), .t2_ovf(t2_ovf), .rxd_in(rxd_in), .rxd_out(rxd_out),
    .rxd_oe(rxd_oe), .txd(txd));
  spmbs_far_model #(.BIT(16)) u_far (.ref_clk(ref_clk), .txd(txd),
    .rxd_out(rxd_out), .rxd_in(rxd_in));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, i, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    r = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    apb(1'b1, i, d);
  endtask : wr

  task automatic rd(input logic [7:0] i);
    apb(1'b0, i, 8'h00);
  endtask : rd

  task automatic wait_serial_control_reg(input logic [7:0] m);
    int n;
    n = 0;
    do begin
      rd(`SPMBS_IDX_SERIAL_CONTROL_REG);
      n++;
    end while ((r & m) === 8'h00 && n < 400);
  endtask : wait_serial_control_reg

  task automatic close_out();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (30000) @(posedge ref_clk);
    fails++;
    close_out();
  end

  initial begin
    void'($urandom(32'h720d2d55));
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    t1_ovf = 1'b1;
    t2_ovf = 1'b0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    foreach (RIDX[i]) begin
      rd(RIDX[i]);
      chk(r, 8'h00);
    end
    rd(8'h40);
    chk({e, r}, 9'h100);
    for (int i = 0; i < 3; i++) begin
      b = (i == 0) ? 8'h40 : ((i == 1) ? 8'h87 : 8'($urandom));
      wr(`SPMBS_IDX_BFC, b);
      rd(`SPMBS_IDX_BFC);
      chk(r, b & 8'hBF);
    end
    wr(`SPMBS_IDX_BFC, 8'h00);
    wr(`SPMBS_IDX_SERIAL_CONTROL_REG, 8'h00);
    b = 8'($urandom);
    fork
      u_far.get_m0(g);
      wr(`SPMBS_IDX_SERIAL_BUFFER, b);
    join
    chk(g, b);
    wait_serial_control_reg(8'h02);
    chk(r, 8'h02);
    b = 8'($urandom);
    fork
      u_far.put_m0(b);
      wr(`SPMBS_IDX_SERIAL_CONTROL_REG, 8'h10);
    join
    wait_serial_control_reg(8'h01);
    chk(r, 8'h11);
    rd(`SPMBS_IDX_SERIAL_BUFFER);
    chk(r, b);
    for (int k = 0; k < 3; k++) begin
      t2_ovf <= (k == 0);
      wr(`SPMBS_IDX_POWER_CONTROL_REG, (k == 2) ? 8'h80 : 8'h00);
      wr(`SPMBS_IDX_TIMER2_CONTROL_REG,
         (k == 0) ? 8'h10 : ((k == 1) ? 8'h30 : 8'h00));
      wr(`SPMBS_IDX_BFC, (k == 1) ? 8'h80 : 8'h00);
      wr(`SPMBS_IDX_SERIAL_CONTROL_REG, 8'h50);
      b = 8'($urandom);
      fork
        u_far.get_uart(g, s);
        wr(`SPMBS_IDX_SERIAL_BUFFER, b);
      join
      chk({s, g}, {1'b1, b});
      wait_serial_control_reg(8'h02);
      chk(r, 8'h52);
    end
    wr(`SPMBS_IDX_SERIAL_CONTROL_REG, 8'h50);
    b = 8'($urandom);
    u_far.put_uart(b, 1'b1, 1'b1);
    rd(`SPMBS_IDX_SERIAL_BUFFER);
    chk(r, b);
    rd(`SPMBS_IDX_SERIAL_CONTROL_REG);
    chk(r, 8'h55);
    g = 8'($urandom);
    u_far.put_uart(g, 1'b1, 1'b0);
    rd(`SPMBS_IDX_SERIAL_BUFFER);
    chk(r, b);
    rd(`SPMBS_IDX_IBR);
    chk(r, 8'h80);
    wr(`SPMBS_IDX_IBR, 8'h00);
    rd(`SPMBS_IDX_IBR);
    chk(r, 8'h00);
    wr(`SPMBS_IDX_SERIAL_CONTROL_REG, 8'h70);
    u_far.put_uart(g, 1'b0, 1'b0);
    rd(`SPMBS_IDX_SERIAL_CONTROL_REG);
    chk(r, 8'h70);
    rd(`SPMBS_IDX_IBR);
    chk(r, 8'h40);
    g = 8'($urandom);
    u_far.put_uart(g, 1'b1, 1'b0);
    rd(`SPMBS_IDX_SERIAL_BUFFER);
    chk(r, g);
    rd(`SPMBS_IDX_IBR);
    chk(r, 8'h00);
    wr(`SPMBS_IDX_CFG, 8'h01);
    b = 8'($urandom);
    u_far.put_uart(b, 1'b1, 1'b0);
    rd(`SPMBS_IDX_SERIAL_BUFFER);
    chk(r, b);
    rd(`SPMBS_IDX_IBR);
    chk(r, 8'h80);
    close_out();
  end
endmodule : tb_top
